// file: rtl/lsc_cfg.svh
// timing and reset constants of the lin mode controller
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

`define LSC_CLK_MHZ          100
`define LSC_RESET_TIME_US    4000
`define LSC_WDOG_TIMEOUT_US  64000
`define LSC_BUS_FILTER_US    30
`define LSC_LOCAL_FILTER_US  30
`define LSC_WAKE_HIGH_US     10
`define LSC_BUS_FILTER_CYC   (`LSC_BUS_FILTER_US * `LSC_CLK_MHZ)
`define LSC_LOCAL_FILTER_CYC (`LSC_LOCAL_FILTER_US * `LSC_CLK_MHZ)
`define LSC_WAKE_HIGH_CYC    (`LSC_WAKE_HIGH_US * `LSC_CLK_MHZ + 1)
`define LSC_RESET_CYC        (`LSC_RESET_TIME_US * `LSC_CLK_MHZ)
`define LSC_WDOG_CYC         (`LSC_WDOG_TIMEOUT_US * `LSC_CLK_MHZ)
// idle pin levels: transmit, bus, wake and trigger sit high on their pull-ups
`define LSC_SYNC_RESET       8'h78
`define LSC_PEND_RESET       1'b0

`endif

// file: rtl/lsc_pkg.sv
// types of the lin mode controller
`default_nettype none
package lsc_pkg;

  typedef logic [23:0] lsc_cnt_t;

  typedef enum logic [2:0] {
    MODE_UNPOWERED,
    MODE_FAILSAFE,
    MODE_NORMAL,
    MODE_SILENT,
    MODE_SLEEP
  } lsc_mode_e;

  // pin levels seen by the block, all asynchronous to the clock
  typedef struct packed {
    logic enable;            // mode enable pin
    logic tx_drive;          // transmit pin driven by host
    logic bus_level;         // lin receiver output, high = recessive
    logic wake_level;        // local wake pin
    logic watchdog_trigger;  // trigger pin, falling edge triggers
    logic battery_ok;        // battery_supply above threshold
    logic vcc_uv;            // regulator undervoltage
    logic bus_below_prewake; // bus below prewake_threshold
  } lsc_pin_in_s;

  typedef struct packed {
    logic bus_dominant;
    logic rx_report;
    logic tx_report;
    logic tx_report_oe;
    logic mcu_reset_n;
    logic regulator_en;
    logic transceiver_en;
    logic watchdog_en;
    logic ext_regulator_switch;
    logic lin_receiver_en;
    logic termination_en;
  } lsc_pin_out_s;

  typedef struct packed {
    logic [7:0]   s1;
    logic [7:0]   s2;
    logic [7:0]   s3;
    lsc_pin_in_s  flt;
    lsc_pin_in_s  flt_d;
    lsc_mode_e    mode;
    lsc_cnt_t     reset_cnt;
    lsc_cnt_t     wd_cnt;
    lsc_cnt_t     bus_cnt;
    lsc_cnt_t     wake_hi_cnt;
    lsc_cnt_t     wake_lo_cnt;
    logic         bus_armed;
    logic         local_ok;
    logic         pending;
    logic         src_local;
    lsc_pin_out_s pins;
  } lsc_state_s;

endpackage

`default_nettype wire

// file: rtl/lsc_mode_ctrl.sv
// operating-mode controller of a lin system basis chip
`timescale 1ns/1ps
`include "lsc_cfg.svh"
`default_nettype none

module lsc_mode_ctrl
#(
  parameter lsc_pkg::lsc_cnt_t RESET_CYCLES = lsc_pkg::lsc_cnt_t'(`LSC_RESET_CYC), // reset hold
  parameter lsc_pkg::lsc_cnt_t WDOG_CYCLES  = lsc_pkg::lsc_cnt_t'(`LSC_WDOG_CYC)   // trigger timeout
)
(
  input  wire logic                  i_ref_clk, // 100 MHz clock
  input  wire logic                  i_rst,     // synchronous reset, high
  input  wire lsc_pkg::lsc_pin_in_s  i_pins,    // asynchronous pin levels
  output var  lsc_pkg::lsc_pin_out_s o_pins,    // pin drives and enables
  output var  lsc_pkg::lsc_mode_e    o_mode     // current mode
);
  import lsc_pkg::*;

  localparam lsc_cnt_t BUS_CYC   = lsc_cnt_t'(`LSC_BUS_FILTER_CYC);
  localparam lsc_cnt_t LOCAL_CYC = lsc_cnt_t'(`LSC_LOCAL_FILTER_CYC);
  localparam lsc_cnt_t HIGH_CYC  = lsc_cnt_t'(`LSC_WAKE_HIGH_CYC);
  localparam lsc_cnt_t ONE       = 24'h000001;

  // saturating count so a long level never wraps into a false match
  function automatic lsc_cnt_t lsc_inc(input lsc_cnt_t v);
    lsc_inc = (v == 24'hFFFFFF) ? v : v + ONE;
  endfunction

  function automatic logic lsc_low_power(input lsc_mode_e m);
    lsc_low_power = (m == MODE_SILENT) || (m == MODE_SLEEP);
  endfunction

  lsc_state_s  st;
  lsc_state_s  next_st;
  lsc_pin_in_s p;
  logic        fall_en;
  logic        rise_bus;
  logic        trig_fall;
  logic        remote_wake;
  logic        local_wake;
  logic        wd_fail;
  logic        uv;
  logic        lp_next;
  logic [7:0]  agree;

  // whole next state: synchronisers, filters, counters, mode, pin drives
  always_comb
  begin
    next_st = st;
    p       = st.flt;
    agree   = ~(st.s2 ^ st.s3);

    // three-stage sync; a level counts once stages two and three agree
    next_st.s1    = i_pins;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.flt   = lsc_pin_in_s'((st.s3 & agree) | (st.flt & ~agree));
    next_st.flt_d = st.flt;

    fall_en   = st.flt_d.enable & ~p.enable;
    rise_bus  = ~st.flt_d.bus_level & p.bus_level;
    trig_fall = st.flt_d.watchdog_trigger & ~p.watchdog_trigger;

    // bus wake filter runs in every mode, so a low begun in normal counts
    next_st.bus_cnt = p.bus_level ? '0 : lsc_inc(st.bus_cnt);
    if (!p.bus_level && st.bus_cnt == BUS_CYC - ONE)
      next_st.bus_armed = 1'b1;
    else if (rise_bus)
      next_st.bus_armed = 1'b0;
    remote_wake = rise_bus && st.bus_armed && lsc_low_power(st.mode);

    // local wake: needs a qualified high phase, or wake high at low-power entry, then a filtered low
    next_st.wake_hi_cnt = p.wake_level ? lsc_inc(st.wake_hi_cnt) : '0;
    if (p.wake_level && st.wake_hi_cnt == HIGH_CYC - ONE)
      next_st.local_ok = 1'b1;
    next_st.wake_lo_cnt = (!p.wake_level && st.local_ok && lsc_low_power(st.mode))
                          ? lsc_inc(st.wake_lo_cnt) : '0;
    local_wake = !p.wake_level && st.local_ok && lsc_low_power(st.mode)
                 && st.wake_lo_cnt == LOCAL_CYC - ONE;
    if (local_wake)
      next_st.local_ok = 1'b0;

    // watchdog only counts in normal; each trigger fall restarts it
    wd_fail = 1'b0;
    if (st.mode != MODE_NORMAL || trig_fall)
      next_st.wd_cnt = '0;
    else
    begin
      next_st.wd_cnt = lsc_inc(st.wd_cnt);
      wd_fail        = (st.wd_cnt == WDOG_CYCLES - ONE);
    end

    // regulator undervoltage matters only while the regulator is on
    uv = p.vcc_uv && st.mode != MODE_SLEEP && st.mode != MODE_UNPOWERED;

    if (st.reset_cnt != '0)
      next_st.reset_cnt = st.reset_cnt - ONE;

    // wake request flag clears once the host has taken normal mode
    if (st.mode == MODE_NORMAL && p.enable)
      next_st.pending = 1'b0;

    // mode sequencing
    case (st.mode)
      MODE_UNPOWERED:
      begin
        if (p.battery_ok)
        begin
          next_st.mode      = MODE_FAILSAFE;
          next_st.reset_cnt = RESET_CYCLES;
        end
      end
      MODE_FAILSAFE, MODE_NORMAL, MODE_SILENT, MODE_SLEEP:
      begin
        if (wd_fail || uv)
        begin
          next_st.mode      = MODE_FAILSAFE;
          next_st.reset_cnt = RESET_CYCLES;
        end
        else if (st.reset_cnt != '0)
          next_st.mode = st.mode;
        else
        begin
          case (st.mode)
            MODE_FAILSAFE:
            begin
              if (p.enable)
                next_st.mode = MODE_NORMAL;
            end
            MODE_NORMAL:
            begin
              // entry ignores the bus level; transmit pin picks the mode, wake level loads local_ok
              if (fall_en)
              begin
                next_st.mode     = p.tx_drive ? MODE_SILENT : MODE_SLEEP;
                next_st.local_ok = p.wake_level;
              end
            end
            MODE_SILENT:
            begin
              if (!p.battery_ok)
                next_st.mode = MODE_FAILSAFE;
              else if (p.enable)
                next_st.mode = MODE_NORMAL;
              else if (remote_wake || local_wake)
                next_st.mode = MODE_FAILSAFE;
            end
            MODE_SLEEP:
            begin
              // the regulator restarts, so the host is held in reset again
              if (!p.battery_ok || p.enable || remote_wake || local_wake)
              begin
                next_st.mode      = MODE_FAILSAFE;
                next_st.reset_cnt = RESET_CYCLES;
              end
            end
            default:
              next_st.mode = MODE_FAILSAFE;
          endcase
        end
      end
      default:
        next_st.mode = MODE_FAILSAFE;
    endcase

    // a wake in the clear cycle still sets the flag
    if (remote_wake || local_wake)
    begin
      next_st.pending   = 1'b1;
      next_st.src_local = local_wake;
    end

    lp_next = lsc_low_power(next_st.mode);

    // pin drives follow the next mode so outputs leave flip-flops directly
    next_st.pins.transceiver_en = (next_st.mode == MODE_NORMAL);
    next_st.pins.bus_dominant   = (next_st.mode == MODE_NORMAL) && !p.tx_drive;
    if (next_st.mode == MODE_NORMAL)
      next_st.pins.rx_report = p.bus_level;
    else if (next_st.mode == MODE_FAILSAFE)
      next_st.pins.rx_report = !next_st.pending;
    else
      next_st.pins.rx_report = (next_st.mode == MODE_SILENT);
    next_st.pins.tx_report_oe = (next_st.mode == MODE_FAILSAFE);
    next_st.pins.tx_report    = !next_st.src_local;
    next_st.pins.mcu_reset_n  = (next_st.reset_cnt == '0) && !wd_fail && !uv
                                && next_st.mode != MODE_SLEEP
                                && next_st.mode != MODE_UNPOWERED;
    next_st.pins.regulator_en = next_st.mode != MODE_SLEEP
                                && next_st.mode != MODE_UNPOWERED;
    next_st.pins.watchdog_en  = (next_st.mode == MODE_NORMAL)
                                || (next_st.mode == MODE_FAILSAFE);
    next_st.pins.ext_regulator_switch = (next_st.mode == MODE_NORMAL)
                                        || (next_st.mode == MODE_FAILSAFE);
    next_st.pins.lin_receiver_en = (next_st.mode == MODE_NORMAL)
                                   || (lp_next && p.bus_below_prewake);
    // weak pull-up only in low power, unless the bus already looks dominant
    next_st.pins.termination_en  = (next_st.mode == MODE_NORMAL)
                                   || (next_st.mode == MODE_FAILSAFE)
                                   || (lp_next && p.bus_below_prewake);
  end

  // single state register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st       <= '0;
      st.s1    <= `LSC_SYNC_RESET;
      st.s2    <= `LSC_SYNC_RESET;
      st.s3    <= `LSC_SYNC_RESET;
      st.flt   <= lsc_pin_in_s'(`LSC_SYNC_RESET); // idle levels, so no false edge follows reset
      st.flt_d <= lsc_pin_in_s'(`LSC_SYNC_RESET);
      st.mode  <= MODE_UNPOWERED;
      st.pending <= `LSC_PEND_RESET;
    end
    else
      st <= next_st;
  end

  assign o_pins = st.pins;
  assign o_mode = st.mode;

endmodule

`default_nettype wire

// file: sim/lsc_mode_ctrl_asserts.sv
// port assertions of the lin mode controller
`timescale 1ns/1ps
`default_nettype none
module lsc_mode_ctrl_chk
(
  input wire logic                 i_ref_clk, // clock
  input wire logic                 i_rst,     // reset
  input wire lsc_pkg::lsc_pin_in_s  i_pins,    // pin levels in
  input wire lsc_pkg::lsc_pin_out_s o_pins,    // pin drives out
  input wire lsc_pkg::lsc_mode_e    o_mode     // mode
);
  import lsc_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // power-up entry and the reset hold that follows it
  sequence s_powered;
    $past(o_mode) == MODE_UNPOWERED && o_mode == MODE_FAILSAFE;
  endsequence
  sequence s_held;
    (o_mode == MODE_FAILSAFE && !o_pins.mcu_reset_n)[*8];
  endsequence
  a_fs_outs: assert property (
    o_mode == MODE_FAILSAFE |-> !o_pins.transceiver_en && o_pins.regulator_en && o_pins.watchdog_en
    && !o_pins.bus_dominant) else $error("failsafe outputs wrong");
  a_normal_outs: assert property (
    o_mode == MODE_NORMAL |-> o_pins.transceiver_en && o_pins.regulator_en && o_pins.watchdog_en)
    else $error("normal outputs wrong");
  a_silent_outs: assert property (
    o_mode == MODE_SILENT |-> o_pins.regulator_en && !o_pins.transceiver_en && !o_pins.bus_dominant)
    else $error("silent outputs wrong");
  a_sleep_outs: assert property (
    o_mode == MODE_SLEEP |-> !o_pins.regulator_en && !o_pins.mcu_reset_n && !o_pins.rx_report)
    else $error("sleep outputs wrong");
  a_switch_mode: assert property (
    o_pins.ext_regulator_switch == (o_mode inside {MODE_NORMAL, MODE_FAILSAFE}))
    else $error("external switch wrong");
  a_reset_fs: assert property (
    $fell(o_pins.mcu_reset_n) |-> o_mode inside {MODE_FAILSAFE, MODE_SLEEP})
    else $error("reset low outside failsafe");
  a_power_hold: assert property (
    s_powered |-> s_held) else $error("power-up reset too short");
  a_fs_source: assert property (
    o_mode == MODE_FAILSAFE |-> o_pins.tx_report_oe) else $error("source not driven");
  a_sleep_exit: assert property (
    o_mode == MODE_SLEEP |=> o_mode inside {MODE_SLEEP, MODE_FAILSAFE}) else $error("bad sleep exit");
  a_fs_exit: assert property (
    o_mode == MODE_FAILSAFE |=> o_mode inside {MODE_FAILSAFE, MODE_NORMAL}) else $error("bad failsafe exit");
  a_normal_term: assert property (
    o_mode == MODE_NORMAL |-> o_pins.lin_receiver_en && o_pins.termination_en)
    else $error("normal receiver off");
endmodule
bind lsc_mode_ctrl lsc_mode_ctrl_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pins(i_pins),
  .o_pins(o_pins), .o_mode(o_mode));
`default_nettype wire

// file: sim/lsc_host_model.sv
// host microcontroller model driving enable, transmit and trigger pins
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model
(
  input  wire logic i_ref_clk, // clock
  input  wire logic i_en,      // wanted enable level
  input  wire logic i_tx,      // wanted transmit level
  input  wire logic i_kick,    // keep the watchdog fed
  output var  logic o_enable,  // enable pin
  output var  logic o_tx,      // transmit pin
  output var  logic o_trig     // trigger pin
);
  logic [4:0] tick;
  initial
  begin
    tick = 5'h00;
    o_enable = 1'b0;
    o_tx = 1'b1;
    o_trig = 1'b1;
  end
  // enable and tx move together so tx is steady around the enable fall
  always @(negedge i_ref_clk)
  begin
    tick <= tick + 5'h01;
    o_enable <= i_en;
    o_tx <= i_tx;
    o_trig <= i_kick ? tick[4] : 1'b1;
  end
endmodule
`default_nettype wire

// file: sim/lsc_mode_ctrl_tb_top.sv
// self-checking bench of the lin mode controller
`timescale 1ns/1ps
`default_nettype none
module lsc_mode_ctrl_tb_top;
  import lsc_pkg::*;
  localparam int RST = 50;
  localparam int WD  = 200;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         en = 1'b0, tx = 1'b1, kick = 1'b1, bus = 1'b1, wake = 1'b1;
  logic         bat = 1'b0, uv = 1'b0, pre = 1'b0;
  logic         h_en, h_tx, h_trig, tx_pin;
  lsc_pin_in_s  pins;
  lsc_pin_out_s op;
  lsc_mode_e    mode;
  int           err_total = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  // the transmit wire is the device's while it reports the wake source
  assign tx_pin = op.tx_report_oe ? op.tx_report : h_tx;
  assign pins = '{h_en, tx_pin, bus, wake, h_trig, bat, uv, pre};
  lsc_host_model u_host (.i_ref_clk(clk), .i_en(en), .i_tx(tx), .i_kick(kick),
    .o_enable(h_en), .o_tx(h_tx), .o_trig(h_trig));
  lsc_mode_ctrl #(.RESET_CYCLES(24'h000032), .WDOG_CYCLES(24'h0000C8)) uut (.i_ref_clk(clk),
    .i_rst(rst), .i_pins(pins), .o_pins(op), .o_mode(mode));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_mode(input lsc_mode_e m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
    chk("mode", m, mode);
  endtask
  // the long reset keeps the device in failsafe even with enable high
  task automatic t_power();
    bat = 1'b1;
    en = 1'b1;
    wait_mode(MODE_FAILSAFE, 20);
    w(RST - 10);
    chk("reset_n", 0, op.mcu_reset_n);
    chk("mode", MODE_FAILSAFE, mode);
    wait_mode(MODE_NORMAL, 40);
    chk("reset_n", 1, op.mcu_reset_n);
  endtask
  task automatic t_normal();
    tx = 1'b0;
    w(8);
    chk("dominant", 1, op.bus_dominant);
    tx = 1'b1;
    bus = 1'b0;
    w(8);
    chk("rx", 0, op.rx_report);
    bus = 1'b1;
    w(8);
  endtask
  task automatic t_silent();
    en = 1'b0;
    wait_mode(MODE_SILENT, 20);
    chk("ext", 0, op.ext_regulator_switch);
    pre = 1'b1;
    w(8);
    chk("term", 1, op.termination_en);
    chk("recv", 1, op.lin_receiver_en);
    pre = 1'b0;
    en = 1'b1;
    wait_mode(MODE_NORMAL, 20);
  endtask
  // a short dominant pulse must not wake, a long one must
  task automatic t_sleep_remote();
    en = 1'b0;
    tx = 1'b0;
    wait_mode(MODE_SLEEP, 20);
    chk("reg", 0, op.regulator_en);
    bus = 1'b0;
    w(1000);
    bus = 1'b1;
    w(20);
    chk("mode", MODE_SLEEP, mode);
    bus = 1'b0;
    w(3100);
    bus = 1'b1;
    wait_mode(MODE_FAILSAFE, 20);
    chk("rx", 0, op.rx_report);
    chk("src", 1, op.tx_report);
    tx = 1'b1;
    en = 1'b1;
    wait_mode(MODE_NORMAL, RST + 40);
  endtask
  task automatic t_local();
    en = 1'b0;
    wait_mode(MODE_SILENT, 20);
    wake = 1'b0;
    w(3100);
    wake = 1'b1;
    wait_mode(MODE_FAILSAFE, 20);
    chk("src", 0, op.tx_report);
    chk("rx", 0, op.rx_report);
    en = 1'b1;
    wait_mode(MODE_NORMAL, 20);
  endtask
  task automatic t_supply();
    en = 1'b0;
    wait_mode(MODE_SILENT, 20);
    bat = 1'b0;
    wait_mode(MODE_FAILSAFE, 20);
    bat = 1'b1;
    en = 1'b1;
    wait_mode(MODE_NORMAL, 20);
    en = 1'b0;
    wait_mode(MODE_SILENT, 20);
    uv = 1'b1;
    wait_mode(MODE_FAILSAFE, 20);
    chk("reset_n", 0, op.mcu_reset_n);
    uv = 1'b0;
    en = 1'b1;
    wait_mode(MODE_NORMAL, RST + 40);
  endtask
  // lows already standing at entry: silent is taken, a stale wake low does not wake
  task automatic t_held_low();
    bus = 1'b0;
    wake = 1'b0;
    w(3100);
    en = 1'b0;
    wait_mode(MODE_SILENT, 20);
    wake = 1'b1;
    w(500);
    wake = 1'b0;
    w(3100);
    chk("mode", MODE_SILENT, mode);
    bus = 1'b1;
    wait_mode(MODE_FAILSAFE, 20);
    chk("src", 1, op.tx_report);
    wake = 1'b1;
    w(20);
    chk("mode", MODE_FAILSAFE, mode);
    en = 1'b1;
    wait_mode(MODE_NORMAL, 20);
  endtask
  task automatic t_watchdog();
    kick = 1'b0;
    wait_mode(MODE_FAILSAFE, WD + 20);
    chk("reset_n", 0, op.mcu_reset_n);
    kick = 1'b1;
  endtask
  // a hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    w(8);
    rst = 1'b0;
    t_power();
    t_normal();
    t_silent();
    t_sleep_remote();
    t_local();
    t_supply();
    t_held_low();
    t_watchdog();
    print_verdict();
  end
endmodule
`default_nettype wire
